// file: tlic_pkg.sv
// Constants, field layout and carrier types of the two-level interrupt controller.
// Assumes one clock edge per machine cycle, and that timer, serial and CPU logic share it.
//
// Behaviour
// [RULE1] Priority register bit per source selects high or low level; reset clears it.
// [RULE2] Low routine yields only to a high request; a high routine never yields.
// [RULE3] With both levels pending in one poll, a high request wins.
// [RULE4] Same-level order: ext 0, timer 0, ext 1, timer 1, serial.
// [RULE5] Timer 2 ranks after serial within either level.
// [RULE6] Flags are sampled each machine cycle and polled in the next one.
// [RULE7] No call while equal/higher level active, mid-instruction, exit or enable/priority write.
// [RULE8] After an exit or an enable/priority access, one more instruction completes first.
// [RULE9] Blocked requests are not remembered; every poll uses fresh samples.
// [RULE10] Acceptance issues a hardware call without status save and marks the level active.
// [RULE11] Vectors 0003H to 002BH in steps of eight per source; reset starts at 0000H.
// [RULE12] Serial and timer 2 flags are never cleared by vectoring.
// [RULE13] Vectoring clears the timer 0/1 flag, and an ext flag only in edge mode.
// [RULE14] Interrupt exit ends the current level and restores the previous status.
// [RULE15] A plain subroutine exit leaves the active level marked.
// [RULE16] Trigger select 0: ext flag is set while the sampled pin is low.
// [RULE17] Trigger select 1: ext flag is set on a high sample followed by a low one.
// [RULE18] Pin drivers hold each level at least one machine cycle.
// [RULE19] A level source holds low until the call and releases before the routine ends.
// [RULE20] Enable register: per-source bits plus a global bit, both needed to request.
// [RULE21] Serial request is receive OR transmit; timer 2 is overflow OR external.
// [RULE22] Timer 2 overflow is polled in the same machine cycle it is set.
// [RULE23] Software writes to request flags act like hardware sets and clears; in level mode the ext flags ignore writes and follow the pin.
package tlic_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_TIMER_CONTROL_REGISTER = 8'h88;
   localparam logic [7:0] ADDR_IE = 8'hA8;
   localparam logic [7:0] ADDR_IP = 8'hB8;

   // Reset values and implemented-bit masks.
   localparam logic [7:0] RST_IE = 8'h00;
   localparam logic [7:0] RST_IP = 8'h00;
   localparam logic [1:0] RST_TRIG = 2'h0;
   localparam logic [7:0] IE_MASK = 8'hBF;
   localparam logic [7:0] IP_MASK = 8'h3F;
   localparam logic [1:0] PIN_IDLE = 2'h3;

   // Field positions.
   localparam int IE_GLOBAL_BIT = 7;
   localparam int TIMER_CONTROL_REGISTER_IT0 = 0;
   localparam int TIMER_CONTROL_REGISTER_IE0 = 1;
   localparam int TIMER_CONTROL_REGISTER_IT1 = 2;
   localparam int TIMER_CONTROL_REGISTER_IE1 = 3;
   localparam int TIMER_CONTROL_REGISTER_TF0 = 5;
   localparam int TIMER_CONTROL_REGISTER_TF1 = 7;

   // Sources in polling order, lowest index first.
   localparam int NUM_SRC = 6;
   localparam int NUM_EXT = 2;
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_TMR0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_TMR1 = 3'h3;
   localparam logic [2:0] SRC_SER = 3'h4;
   localparam logic [2:0] SRC_TMR2 = 3'h5;

   // Vector of source n is VEC_BASE + n * 8.
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] RESET_VEC = 16'h0000;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tlic_sfr_req_t;

   typedef struct packed {
      logic last_cycle;
      logic interrupt_exit_instruction;
   } tlic_cpu_t;

   typedef struct packed {
      logic rx_done;
      logic tx_done;
      logic t2_ovf;
      logic t2_ext;
   } tlic_periph_t;

   typedef struct packed {
      logic call;
      logic [15:0] addr;
   } tlic_vec_t;

   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } tlic_sync_t;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] prio;
      logic [1:0] trig;
      logic [1:0] ext_flag;
      logic [1:0] tmr_flag;
      logic [1:0] pin_prev;
      logic ser_smp;
      logic t2x_smp;
      logic hi_act;
      logic lo_act;
      tlic_vec_t vec;
      logic [7:0] rdata;
   } tlic_state_t;

endpackage

// file: tlic_sync.sv
// Two-stage synchroniser for the external request pins.
// Assumes the pins are asynchronous to mclk; reset holds both stages at the idle level.
`timescale 1ns/1ps

module tlic_sync (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [1:0] pin_raw,
   output logic [1:0] pin_s
);

   tlic_pkg::tlic_sync_t st_ff;
   tlic_pkg::tlic_sync_t nxt_st;

   // The first stage feeds only the second, so a metastable value never reaches logic.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.stage1 = pin_raw;
      nxt_st.stage2 = st_ff.stage1;
   end

   // Idle-high reset keeps the edge detector from seeing a false fall at start-up.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff.stage1 <= tlic_pkg::PIN_IDLE;
         st_ff.stage2 <= tlic_pkg::PIN_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_s = st_ff.stage2;

endmodule

// file: tlic_ctrl.sv
// Two-level interrupt controller: request flags, enable and priority registers,
// polling, level tracking and the hardware vector call request.
// Assumes one mclk edge per machine cycle; the CPU drives last_cycle and interrupt_exit_instruction on the
// same clock and performs the stack push and program counter load itself.
`timescale 1ns/1ps

module tlic_ctrl (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [1:0] ext_request_pin_n,
   input wire logic [1:0] timer_ovf_set,
   input wire tlic_pkg::tlic_periph_t periph,
   input wire tlic_pkg::tlic_cpu_t cpu,
   input wire tlic_pkg::tlic_sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   output tlic_pkg::tlic_vec_t vec,
   output logic [1:0] level_active,
   output logic [1:0] ext_flag,
   output logic [1:0] timer_flag
);

   tlic_pkg::tlic_state_t st_ff;
   tlic_pkg::tlic_state_t nxt_st;

   logic [1:0] pin_s;
   logic [5:0] req;
   logic [5:0] hreq;
   logic [5:0] lreq;
   logic [3:0] hpick;
   logic [3:0] lpick;
   logic [2:0] pick;
   logic blocked;
   logic take_hi;
   logic take_lo;
   logic take;
   logic wr_ie;
   logic wr_ip;
   logic wr_timer_control_register;
   logic reg_access;
   logic [7:0] timer_control_register_view;

   // Returns {found, index} of the lowest-index set bit, which is the polling order.
   function automatic logic [3:0] first_req(input logic [5:0] r);
      logic [3:0] res;
      res = 4'h0;
      for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (r[i]) begin
            res = {1'b1, 3'(i)}; // [RULE4] [RULE5]
         end
      end
      return res;
   endfunction

   // Pins arrive from outside the clock domain.
   tlic_sync u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .pin_raw(ext_request_pin_n),
      .pin_s(pin_s)
   );

   // Register decode for writes; any access to enable or priority also blocks a call.
   always_comb begin
      wr_ie = 1'b0;
      wr_ip = 1'b0;
      wr_timer_control_register = 1'b0;
      if (sfr.addr == tlic_pkg::ADDR_IE) begin
         wr_ie = sfr.wr;
      end else if (sfr.addr == tlic_pkg::ADDR_IP) begin
         wr_ip = sfr.wr;
      end else if (sfr.addr == tlic_pkg::ADDR_TIMER_CONTROL_REGISTER) begin
         wr_timer_control_register = sfr.wr;
      end
   end

   // Reads count as well as writes, so a read of either register also defers vectoring.
   assign reg_access = (sfr.wr | sfr.rd) &
                       ((sfr.addr == tlic_pkg::ADDR_IE) | (sfr.addr == tlic_pkg::ADDR_IP)); // [RULE8]

   // Request vector in polling order; serial and timer 2 are each an OR of two flags.
   assign req = {periph.t2_ovf | st_ff.t2x_smp, // [RULE21] [RULE22]
                 st_ff.ser_smp, // [RULE21]
                 st_ff.tmr_flag[1],
                 st_ff.ext_flag[1],
                 st_ff.tmr_flag[0],
                 st_ff.ext_flag[0]} &
                st_ff.enable[5:0] &
                {6{st_ff.enable[tlic_pkg::IE_GLOBAL_BIT]}}; // [RULE20]

   // Split by level; only this cycle's samples are looked at, nothing is latched.
   assign hreq = req & st_ff.prio[5:0]; // [RULE1] [RULE9]
   assign lreq = req & ~st_ff.prio[5:0]; // [RULE1] [RULE9]
   assign hpick = first_req(hreq);
   assign lpick = first_req(lreq);

   // Mid-instruction, interrupt exit, or enable/priority access all hold the call back.
   assign blocked = ~cpu.last_cycle | cpu.interrupt_exit_instruction | reg_access; // [RULE7] [RULE8]

   // High wins over low; an active high level blocks both, an active low blocks low.
   assign take_hi = ~blocked & hpick[3] & ~st_ff.hi_act; // [RULE2] [RULE3] [RULE7]
   assign take_lo = ~blocked & ~hpick[3] & lpick[3] &
                    ~st_ff.hi_act & ~st_ff.lo_act; // [RULE2] [RULE3] [RULE7]
   assign take = take_hi | take_lo;
   assign pick = take_hi ? hpick[2:0] : lpick[2:0];

   // Readable image of the timer control bits held here; unheld bits read zero.
   always_comb begin
      timer_control_register_view = 8'h00;
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_IT0] = st_ff.trig[0];
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_IE0] = st_ff.ext_flag[0];
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_IT1] = st_ff.trig[1];
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_IE1] = st_ff.ext_flag[1];
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_TF0] = st_ff.tmr_flag[0];
      timer_control_register_view[tlic_pkg::TIMER_CONTROL_REGISTER_TF1] = st_ff.tmr_flag[1];
   end

   // Next-state logic for the whole controller.
   always_comb begin
      nxt_st = st_ff;

      // Sample the pins and peripheral flags once per machine cycle for the next poll.
      nxt_st.pin_prev = pin_s; // [RULE6]
      nxt_st.ser_smp = periph.rx_done | periph.tx_done; // [RULE6]
      nxt_st.t2x_smp = periph.t2_ext; // [RULE6]

      // Enable and priority registers; unimplemented bits stay zero.
      if (wr_ie) begin
         nxt_st.enable = sfr.wdata & tlic_pkg::IE_MASK; // [RULE20]
      end
      if (wr_ip) begin
         nxt_st.prio = sfr.wdata & tlic_pkg::IP_MASK; // [RULE1]
      end
      if (wr_timer_control_register) begin
         nxt_st.trig[0] = sfr.wdata[tlic_pkg::TIMER_CONTROL_REGISTER_IT0];
         nxt_st.trig[1] = sfr.wdata[tlic_pkg::TIMER_CONTROL_REGISTER_IT1];
      end

      // External flags: level mode mirrors the pin, edge mode latches a fall.
      for (int i = 0; i < tlic_pkg::NUM_EXT; i++) begin
         if (!st_ff.trig[i]) begin
            nxt_st.ext_flag[i] = ~pin_s[i]; // [RULE16] [RULE13]
         end else begin
            if (wr_timer_control_register) begin
               nxt_st.ext_flag[i] = sfr.wdata[(i == 0) ? tlic_pkg::TIMER_CONTROL_REGISTER_IE0
                                                       : tlic_pkg::TIMER_CONTROL_REGISTER_IE1]; // [RULE23]
            end else if (take && pick == ((i == 0) ? tlic_pkg::SRC_EXT0
                                                   : tlic_pkg::SRC_EXT1)) begin
               nxt_st.ext_flag[i] = 1'b0; // [RULE13]
            end
            // A fresh edge wins over any clear in the same cycle.
            if (st_ff.pin_prev[i] && !pin_s[i]) begin
               nxt_st.ext_flag[i] = 1'b1; // [RULE17]
            end
         end
      end

      // Timer 0/1 overflow flags: software write, vector clear, then hardware set wins.
      for (int i = 0; i < 2; i++) begin
         if (wr_timer_control_register) begin
            nxt_st.tmr_flag[i] = sfr.wdata[(i == 0) ? tlic_pkg::TIMER_CONTROL_REGISTER_TF0
                                                    : tlic_pkg::TIMER_CONTROL_REGISTER_TF1]; // [RULE23]
         end else if (take && pick == ((i == 0) ? tlic_pkg::SRC_TMR0
                                                : tlic_pkg::SRC_TMR1)) begin
            nxt_st.tmr_flag[i] = 1'b0; // [RULE13]
         end
         if (timer_ovf_set[i]) begin
            nxt_st.tmr_flag[i] = 1'b1;
         end
      end
      // Serial and timer 2 flags live in their own blocks; no clear is ever sent. [RULE12]

      // Interrupt exit closes the innermost level: high if set, else low.
      if (cpu.interrupt_exit_instruction) begin
         if (st_ff.hi_act) begin
            nxt_st.hi_act = 1'b0; // [RULE14]
         end else begin
            nxt_st.lo_act = 1'b0; // [RULE14]
         end
      end
      // A plain subroutine exit has no input here, so the levels stay marked. [RULE15]

      // Accepted request: one-cycle call strobe, vector address, level marked active.
      nxt_st.vec.call = take; // [RULE10]
      if (take) begin
         nxt_st.vec.addr = tlic_pkg::VEC_BASE + 16'({pick, 3'h0}); // [RULE11]
      end
      if (take_hi) begin
         nxt_st.hi_act = 1'b1; // [RULE10]
      end
      if (take_lo) begin
         nxt_st.lo_act = 1'b1; // [RULE10]
      end

      // Read data lag the address by one cycle; unmapped addresses read zero.
      if (sfr.addr == tlic_pkg::ADDR_IE) begin
         nxt_st.rdata = st_ff.enable;
      end else if (sfr.addr == tlic_pkg::ADDR_IP) begin
         nxt_st.rdata = st_ff.prio;
      end else if (sfr.addr == tlic_pkg::ADDR_TIMER_CONTROL_REGISTER) begin
         nxt_st.rdata = timer_control_register_view;
      end else begin
         nxt_st.rdata = 8'h00;
      end
   end

   // Control state clears on reset except pin_prev, which loads the idle level; the vector output shows the reset vector.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff.enable <= tlic_pkg::RST_IE;
         st_ff.prio <= tlic_pkg::RST_IP; // [RULE1]
         st_ff.trig <= tlic_pkg::RST_TRIG;
         st_ff.ext_flag <= 2'h0;
         st_ff.tmr_flag <= 2'h0;
         st_ff.pin_prev <= tlic_pkg::PIN_IDLE;
         st_ff.ser_smp <= 1'b0;
         st_ff.t2x_smp <= 1'b0;
         st_ff.hi_act <= 1'b0;
         st_ff.lo_act <= 1'b0;
         st_ff.vec.call <= 1'b0;
         st_ff.vec.addr <= tlic_pkg::RESET_VEC; // [RULE11]
         st_ff.rdata <= 8'h00;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Every output is a field of the state register.
   assign sfr_rdata = st_ff.rdata;
   assign vec = st_ff.vec;
   assign level_active = {st_ff.hi_act, st_ff.lo_act};
   assign ext_flag = st_ff.ext_flag;
   assign timer_flag = st_ff.tmr_flag;

endmodule

// file: tlic_ctrl_sva.sv
// Port-level assertions for the two-level interrupt controller.
// Bound to tlic_ctrl; sees only its ports and the machine-cycle clock.
`timescale 1ns/1ps
module tlic_ctrl_sva (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [1:0] ext_request_pin_n,
   input wire logic [1:0] timer_ovf_set,
   input wire tlic_pkg::tlic_periph_t periph,
   input wire tlic_pkg::tlic_cpu_t cpu,
   input wire tlic_pkg::tlic_sfr_req_t sfr,
   input wire logic [7:0] sfr_rdata,
   input wire tlic_pkg::tlic_vec_t vec,
   input wire logic [1:0] level_active,
   input wire logic [1:0] ext_flag,
   input wire logic [1:0] timer_flag
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // Cycles that touch the enable or priority register, or write the flag register.
   logic reg_hit;
   logic flag_wr;
   assign reg_hit = (sfr.wr || sfr.rd) && (sfr.addr inside {8'hA8, 8'hB8});
   assign flag_wr = sfr.wr && sfr.addr == 8'h88;
   call_boundary_a: assert property (
      vec.call |-> $past(cpu.last_cycle) && !$past(cpu.interrupt_exit_instruction))
      else $error("call outside an instruction boundary");
   access_gap_a: assert property (
      vec.call |-> !$past(reg_hit))
      else $error("call in a register access cycle");
   high_locked_a: assert property (
      vec.call |-> !$past(level_active[1]))
      else $error("high level routine was pre-empted");
   low_yields_a: assert property (
      vec.call && $past(level_active[0]) |-> level_active == 2'h3)
      else $error("low routine pre-empted by a low request");
   level_mark_a: assert property (
      vec.call |-> $onehot(level_active & ~$past(level_active)))
      else $error("call did not mark exactly one new level");
   vector_table_a: assert property (
      vec.call |-> vec.addr inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B})
      else $error("call to an address outside the vector table");
   reset_vector_a: assert property (
      $rose(nrst) |-> vec.addr == 16'h0000 && level_active == 2'h0)
      else $error("wrong state after reset");
   exit_ends_a: assert property (
      cpu.interrupt_exit_instruction && level_active[1] |=> !level_active[1])
      else $error("exit did not end the high level");
   plain_ret_a: assert property (
      !cpu.interrupt_exit_instruction |=> vec.call || $stable(level_active))
      else $error("level changed without exit or call");
   timer_clear_a: assert property (
      vec.call && vec.addr == 16'h000B |-> !timer_flag[0] || $past(timer_ovf_set[0] || flag_wr))
      else $error("timer 0 flag not cleared by its call");
   cover property (vec.call && level_active == 2'h3);
   cover property (cpu.interrupt_exit_instruction && level_active == 2'h3);
   cover property (vec.call && vec.addr == 16'h002B);
endmodule
bind tlic_ctrl tlic_ctrl_sva u_sva (.mclk(mclk), .nrst(nrst),
   .ext_request_pin_n(ext_request_pin_n),
   .timer_ovf_set(timer_ovf_set), .periph(periph), .cpu(cpu), .sfr(sfr), .sfr_rdata(sfr_rdata),
   .vec(vec), .level_active(level_active), .ext_flag(ext_flag), .timer_flag(timer_flag));

// file: tlic_far_model.sv
// Far-side model: the CPU core's instruction boundaries and the external request sources.
// Assumes the bench steers run, ret_req and req just after falling edges.
`timescale 1ns/1ps
module tlic_far_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire tlic_pkg::tlic_vec_t vec,
   input wire logic run,
   input wire logic ret_req,
   input wire logic [1:0] req,
   output tlic_pkg::tlic_cpu_t cpu,
   output logic [1:0] pin_n
);
   logic call_d_ff;
   // The hardware call takes two cycles, so no instruction ends inside it.
   // One assignment drives the whole struct, so no field has a second driver.
   assign cpu = {run && !vec.call && !call_d_ff, ret_req};
   // A source pulls only an idle-high pin low, and releases it once its call is seen.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         call_d_ff <= 1'b0;
         pin_n <= 2'h3;
      end else begin
         call_d_ff <= vec.call;
         for (int i = 0; i < 2; i++) begin
            if (req[i] && pin_n[i]) begin
               pin_n[i] <= 1'b0;
            end else if (vec.call && vec.addr == (i == 0 ? 16'h0003 : 16'h0013)) begin
               pin_n[i] <= 1'b1;
            end
         end
      end
   end
endmodule

// file: testbench.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes the far-side model stands in for the CPU core and the request pins.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   logic mclk, nrst, run, ret_req;
   logic [1:0] req, tset, lvl, ext_flag, timer_flag, w;
   logic [1:0] pin_n;
   logic [7:0] rdata, en_v, pr_v, tc_v;
   logic [5:0] pend;
   logic [3:0] win;
   int n_fail, cmp_count;
   tlic_pkg::tlic_periph_t periph;
   tlic_pkg::tlic_cpu_t cpu;
   tlic_pkg::tlic_sfr_req_t sfr;
   tlic_pkg::tlic_vec_t vec;
   tlic_ctrl DUT (.mclk(mclk), .nrst(nrst), .ext_request_pin_n(pin_n), .timer_ovf_set(tset),
      .periph(periph), .cpu(cpu), .sfr(sfr), .sfr_rdata(rdata), .vec(vec),
      .level_active(lvl), .ext_flag(ext_flag), .timer_flag(timer_flag));
   tlic_far_model u_far (.mclk(mclk), .nrst(nrst), .vec(vec), .run(run), .ret_req(ret_req),
      .req(req), .cpu(cpu), .pin_n(pin_n));
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask
   // Each access takes two cycles so a strobe never toggles twice in one step.
   task automatic wr(logic [7:0] a, logic [7:0] d);
      sfr.addr = a;
      sfr.wdata = d;
      sfr.wr = 1'b1;
      cyc(1);
      sfr.wr = 1'b0;
      cyc(1);
   endtask
   task automatic rdchk(logic [7:0] a, logic [7:0] e);
      sfr.addr = a;
      sfr.rd = 1'b1;
      cyc(1);
      sfr.rd = 1'b0;
      `CHK(rdata, e)
      cyc(1);
   endtask
   // Waits a bounded time for a call and checks where it goes.
   task automatic wcall(logic [15:0] e);
      for (int k = 0; k < 30 && vec.call !== 1'b1; k++)
         cyc(1);
      `CHK(vec.call, 1'b1)
      `CHK(vec.addr, e)
   endtask
   task automatic nocall(int n);
      repeat (n) begin
         cyc(1);
         `CHK(vec.call, 1'b0)
      end
   endtask
   task automatic interrupt_exit_instruction();
      ret_req = 1'b1;
      cyc(1);
      ret_req = 1'b0;
      cyc(1);
   endtask
   // High level first, then the lowest polling index; 7 means nothing is requested.
   function automatic logic [3:0] winner(logic [5:0] p, logic [5:0] hi);
      for (int i = 0; i < 6; i++)
         if (p[i] && hi[i]) return {1'b1, 3'(i)};
      for (int i = 0; i < 6; i++)
         if (p[i]) return {1'b0, 3'(i)};
      return 4'h7;
   endfunction
   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // The whole sequence needs about 500 cycles.
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      {nrst, run, ret_req, req, tset, periph, sfr} = '0;
      void'($urandom(10));
      cyc(8);
      nrst = 1'b1;
      `CHK(vec.addr, 16'h0000)
      rdchk(8'hB8, 8'h00);
      rdchk(8'hA8, 8'h00);
      // Random flag sets, enables and levels; ext and timer 0/1 flags are raised by software writes, serial and timer 2 through periph.
      repeat (16) begin
         en_v = 8'h80 | 8'($urandom);
         pr_v = 8'($urandom);
         pend = 6'($urandom);
         w = 2'($urandom);
         wr(8'hA8, en_v);
         wr(8'hB8, pr_v);
         rdchk(8'hA8, en_v & 8'hBF);
         rdchk(8'hB8, pr_v & 8'h3F);
         rdchk(8'h99, 8'h00);
         wr(8'h88, 8'h05);
         // The flag image must read back as written, unheld bits as zero.
         tc_v = {pend[3], 1'b0, pend[1], 1'b0, pend[2], 1'b1, pend[0], 1'b1};
         wr(8'h88, tc_v);
         rdchk(8'h88, tc_v);
         periph = {pend[4] & w[0], pend[4] & ~w[0], pend[5] & w[1], pend[5] & ~w[1]};
         win = winner(pend & en_v[5:0], pr_v[5:0]);
         cyc(2);
         run = 1'b1;
         if (win[2:0] == 3'h7) begin
            nocall(6);
         end else begin
            wcall(16'h0003 + 16'({win[2:0], 3'h0}));
            `CHK(lvl, win[3] ? 2'h2 : 2'h1)
            pend[win[2:0]] = 1'b0;
            `CHK({timer_flag, ext_flag}, {pend[3], pend[1], pend[2], pend[0]})
         end
         run = 1'b0;
         periph = '0;
         wr(8'h88, 8'h00);
         interrupt_exit_instruction();
         interrupt_exit_instruction();
         `CHK(lvl, 2'h0)
      end
      // Level-triggered pin: flag follows the pin and survives the call.
      wr(8'hA8, 8'h81);
      run = 1'b1;
      req = 2'h1;
      cyc(1);
      req = 2'h0;
      wcall(16'h0003);
      `CHK(ext_flag[0], 1'b1)
      run = 1'b0;
      cyc(6);
      interrupt_exit_instruction();
      run = 1'b1;
      nocall(8);
      // Edge-triggered pin: the call clears the flag.
      wr(8'h88, 8'h04);
      wr(8'hA8, 8'h84);
      req = 2'h2;
      cyc(1);
      req = 2'h0;
      wcall(16'h0013);
      `CHK(ext_flag[1], 1'b0)
      run = 1'b0;
      interrupt_exit_instruction();
      // Nesting: low timer 1, then high timer 0 pre-empts, then nothing pre-empts high.
      wr(8'hA8, 8'h8A);
      wr(8'hB8, 8'h02);
      wr(8'h88, 8'h80);
      run = 1'b1;
      wcall(16'h001B);
      tset = 2'h1;
      cyc(1);
      tset = 2'h0;
      wcall(16'h000B);
      `CHK(lvl, 2'h3)
      wr(8'h88, 8'hA0);
      nocall(6);
      wr(8'h88, 8'h80);
      interrupt_exit_instruction();
      `CHK(lvl, 2'h1)
      nocall(4);
      interrupt_exit_instruction();
      wcall(16'h001B);
      run = 1'b0;
      wr(8'h88, 8'h00);
      interrupt_exit_instruction();
      // Reading the priority register each cycle holds a pending call back.
      wr(8'h88, 8'h20);
      sfr.addr = 8'hB8;
      sfr.rd = 1'b1;
      run = 1'b1;
      nocall(5);
      sfr.rd = 1'b0;
      wcall(16'h000B);
      run = 1'b0;
      interrupt_exit_instruction();
      // A request cancelled while blocked is forgotten.
      wr(8'h88, 8'h20);
      cyc(3);
      wr(8'h88, 8'h00);
      run = 1'b1;
      nocall(5);
      report_and_stop();
   end
endmodule
